//--- inc/kbg_pkg.sv
package kbg_pkg;

    // host i/o locations
    localparam logic [15:0] ADDR_DATA   = 16'h0060;
    localparam logic [15:0] ADDR_CMD    = 16'h0064;
    localparam logic [15:0] ADDR_FAST   = 16'h0092;
    localparam int          CMD_SEL_BIT = 2;

    // handshake status layout
    localparam int          ST_OBF_BIT   = 0;
    localparam int          ST_IBF_BIT   = 1;
    localparam int          ST_CD_BIT    = 3;
    localparam logic [7:0]  ST_USER_MASK = 8'hF4;
    localparam logic [7:0]  ST_RESET     = 8'h00;

    // fast gate/reset port layout
    localparam logic [7:0]  FAST_RESET     = 8'h24;
    localparam logic [7:0]  FAST_FIXED     = 8'h24;
    localparam logic [7:0]  FAST_LIVE_MASK = 8'h03;
    localparam int          FAST_GATE_BIT  = 1;
    localparam int          FAST_RST_BIT   = 0;
    localparam int          CFG_FAST_EN_BIT = 2;

    // value returned for a decoded address with nothing behind it
    localparam logic [7:0]  UNMAPPED_DATA = 8'hFF;

    // system clock
    localparam int CLK_PERIOD_NS = 10;

    // controller reset stretch: 24 periods of 16 MHz
    localparam int CTRL_RST_MIN_PERIODS = 24;
    localparam int CTRL_RST_REF_MHZ     = 16;
    localparam int CTRL_RST_MIN_NS =
        (CTRL_RST_MIN_PERIODS * 1000 + CTRL_RST_REF_MHZ - 1)
        / CTRL_RST_REF_MHZ;
    localparam int CTRL_RST_CYC =
        (CTRL_RST_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // controller clock synthesis: 12 MHz from 14.318 MHz reference
    localparam int REF_KHZ  = 14318;
    localparam int CTRL_KHZ = 12000;

    // alternate reset timing defaults
    localparam int ALT_DELAY_NS = 14000;
    localparam int ALT_PULSE_NS = 6000;

    localparam int CNT_W = 16;

endpackage : kbg_pkg

//--- rtl/kbg_alt_reset_timer.sv
`timescale 1ns/1ns
module kbg_alt_reset_timer #(
    parameter int DELAY_CYC = 1400,
    parameter int PULSE_CYC = 600
) (
    input  wire logic clk_sys,
    input  wire logic reset,
    input  wire logic start,
    output logic      pulse_n,
    output logic      busy
);

    typedef enum logic [1:0] {IDLE, WAIT, PULSE} kbg_tmr_t;

    kbg_tmr_t                     state_reg;
    logic [kbg_pkg::CNT_W-1:0]    cnt_reg;

    localparam logic [kbg_pkg::CNT_W-1:0] DLY_LAST =
        kbg_pkg::CNT_W'(DELAY_CYC - 1);
    localparam logic [kbg_pkg::CNT_W-1:0] PLS_LAST =
        kbg_pkg::CNT_W'(PULSE_CYC - 1);

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            state_reg <= IDLE;
            cnt_reg   <= '0;
        end else begin
            unique case (state_reg)
                IDLE: begin
                    cnt_reg <= '0;
                    if (start) state_reg <= WAIT;
                end
                WAIT: begin
                    if (cnt_reg == DLY_LAST) begin
                        cnt_reg   <= '0;
                        state_reg <= PULSE;
                    end else begin
                        cnt_reg <= cnt_reg + 1'b1;
                    end
                end
                PULSE: begin
                    if (cnt_reg == PLS_LAST) begin
                        cnt_reg   <= '0;
                        state_reg <= IDLE;
                    end else begin
                        cnt_reg <= cnt_reg + 1'b1;
                    end
                end
                default: state_reg <= IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) pulse_n <= 1'b1;
        else       pulse_n <= !(state_reg == PULSE); // RULE_15
    end

    assign busy = (state_reg != IDLE);

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);

    pulse_len_a: assert property ($rose(pulse_n) |-> // RULE_15
        $past(state_reg, 2) == PULSE && $past(cnt_reg, 2) == PLS_LAST)
        else $error("alternate reset pulse width wrong");
    pulse_delay_a: assert property ($fell(pulse_n) |-> // RULE_16
        $past(state_reg, 2) == WAIT && $past(cnt_reg, 2) == DLY_LAST)
        else $error("alternate reset delay wrong");

endmodule : kbg_alt_reset_timer

//--- rtl/kbg_top.sv
`timescale 1ns/1ns
// What this block does
// RULE_01: status bits: output full 0, input full 1, command 3
// RULE_02: status clears on reset, host read-only
// RULE_03: host write loads command flag from address bit two
// RULE_04: host data or command write sets input full
// RULE_05: controller input buffer read clears input full
// RULE_06: controller output write sets, host read clears output full; code clears it on a host data read only in enable-flags mode
// RULE_07: 0x60 write is data, 0x64 command, 0x64 reads status
// RULE_08: enable-flags mode: host data read clears flag, irq
// RULE_09: derive 12 MHz controller clock from 14.318 MHz
// RULE_10: controller reset held at least 24 periods of 16 MHz
// RULE_11: bus reset drives serial lines low, status 00h
// RULE_12: fast port accessible only when config bit 2 set
// RULE_13: fast port reads 24h pattern on fixed bits
// RULE_14: fast port bit 1 drives alternate gate line
// RULE_15: fast port bit 0 write 1 starts delayed low pulse
// RULE_16: pulse delay and width are parameters
// RULE_17: no new pulse until bit 0 returns to 0
// RULE_18: reset clears bit 0, alternate reset high
// RULE_19: cpu reset output ANDs both pulses, polarity selectable; code ANDs in the alternate pulse only while config bit 2 is set
// RULE_20: address mask low only when both gates low
// RULE_21: pulse timing counted from clock with derived counts
module kbg_top #(
    parameter int ALT_DELAY_NS = kbg_pkg::ALT_DELAY_NS,
    parameter int ALT_PULSE_NS = kbg_pkg::ALT_PULSE_NS
) (
    input  wire logic        clk_sys,
    input  wire logic        reset,
    // host i/o port
    input  wire logic        host_wr,
    input  wire logic        host_rd,
    input  wire logic [15:0] host_addr,
    input  wire logic [7:0]  host_wdata,
    output logic      [7:0]  host_rdata,
    output logic             host_rd_ack,
    // embedded controller side
    input  wire logic        ec_in_rd,
    output logic      [7:0]  ec_in_data,
    input  wire logic        ec_out_wr,
    input  wire logic [7:0]  ec_out_wdata,
    input  wire logic        ec_status_wr,
    input  wire logic [7:0]  ec_status_wdata,
    output logic      [7:0]  ec_status,
    input  wire logic        enable_flags,
    input  wire logic        kb_irq_port_bit,
    output logic             kb_irq,
    output logic             input_full_irq_n,
    // serial lines, open drain
    input  wire logic        kb_clock_drive_low,
    input  wire logic        kb_data_drive_low,
    input  wire logic        aux_clock_drive_low,
    input  wire logic        aux_data_drive_low,
    output logic             kb_clock_line_o,
    output logic             kb_clock_line_oe,
    output logic             kb_data_line_o,
    output logic             kb_data_line_oe,
    output logic             aux_clock_line_o,
    output logic             aux_clock_line_oe,
    output logic             aux_data_line_o,
    output logic             aux_data_line_oe,
    // controller clock and reset
    input  wire logic        ref_clk_pin,
    output logic             ctrl_clk_tick,
    input  wire logic        ctrl_reset_req,
    output logic             ctrl_reset,
    // gate and reset
    input  wire logic [7:0]  kbd_reset_gate_cfg,
    input  wire logic        ctrl_gate_port_bit,
    input  wire logic        kbd_reset_n,
    input  wire logic        gp_polarity_invert,
    output logic             alt_gate_line,
    output logic             alt_cpu_reset_n,
    output logic             kbd_cpu_reset,
    output logic             cpu_addr20_mask_n
);

    localparam int ALT_DELAY_CYC = // RULE_21
        (ALT_DELAY_NS + kbg_pkg::CLK_PERIOD_NS - 1) / kbg_pkg::CLK_PERIOD_NS;
    localparam int ALT_PULSE_CYC =
        (ALT_PULSE_NS + kbg_pkg::CLK_PERIOD_NS - 1) / kbg_pkg::CLK_PERIOD_NS;
    localparam logic [15:0] REF_KHZ_W  = 16'(kbg_pkg::REF_KHZ);
    localparam logic [15:0] CTRL_KHZ_W = 16'(kbg_pkg::CTRL_KHZ);
    localparam logic [kbg_pkg::CNT_W-1:0] CTRL_RST_W =
        kbg_pkg::CNT_W'(kbg_pkg::CTRL_RST_CYC);

    logic                      obf_reg;
    logic                      ibf_reg;
    logic                      cd_reg;
    logic [7:0]                user_reg;
    logic [7:0]                host_buffer_reg;
    logic [7:0]                out_buffer_reg;
    logic                      fast_gate_reg;
    logic                      fast_rst_reg;
    logic [7:0]                status_next;
    logic                      fast_en;
    logic                      wr_data_cmd;
    logic                      rd_data;
    logic                      rd_status;
    logic                      wr_fast;
    logic                      rd_fast;
    logic                      alt_start;
    logic                      alt_pulse_n;
    logic                      alt_busy;
    logic [2:0]                ref_sync_reg;
    logic [15:0]               acc_reg;
    logic [15:0]               acc_sum;
    logic [1:0]                req_sync_reg;
    logic [kbg_pkg::CNT_W-1:0] rst_cnt_reg;
    logic                      kbd_rst_comb_n;

    // host decode
    assign fast_en     = kbd_reset_gate_cfg[kbg_pkg::CFG_FAST_EN_BIT];
    assign wr_data_cmd = host_wr && (host_addr == kbg_pkg::ADDR_DATA ||
                                     host_addr == kbg_pkg::ADDR_CMD); // RULE_07
    assign rd_data     = host_rd && host_addr == kbg_pkg::ADDR_DATA;
    assign rd_status   = host_rd && host_addr == kbg_pkg::ADDR_CMD;
    assign wr_fast     = host_wr && fast_en &&
                         host_addr == kbg_pkg::ADDR_FAST; // RULE_12
    assign rd_fast     = host_rd && fast_en &&
                         host_addr == kbg_pkg::ADDR_FAST; // RULE_12

    // status assembly
    always_comb begin
        status_next = user_reg & kbg_pkg::ST_USER_MASK;
        status_next[kbg_pkg::ST_OBF_BIT] = obf_reg; // RULE_01
        status_next[kbg_pkg::ST_IBF_BIT] = ibf_reg;
        status_next[kbg_pkg::ST_CD_BIT]  = cd_reg;
    end
    assign ec_status = status_next; // RULE_02

    // input full: host write sets, controller read clears, set wins
    always_ff @(posedge clk_sys) begin
        if (reset)            ibf_reg <= 1'b0; // RULE_11
        else if (wr_data_cmd) ibf_reg <= 1'b1; // RULE_04
        else if (ec_in_rd)    ibf_reg <= 1'b0; // RULE_05
    end

    always_ff @(posedge clk_sys) begin
        if (reset)            cd_reg <= 1'b0;
        else if (wr_data_cmd) cd_reg <= host_addr[kbg_pkg::CMD_SEL_BIT]; // RULE_03
    end

    // output full: controller write sets, host data read clears in enable-flags mode, set wins
    always_ff @(posedge clk_sys) begin
        if (reset)                         obf_reg <= 1'b0;
        else if (ec_out_wr)                obf_reg <= 1'b1; // RULE_06
        else if (rd_data && enable_flags)  obf_reg <= 1'b0; // RULE_08
    end

    always_ff @(posedge clk_sys) begin
        if (reset)             user_reg <= kbg_pkg::ST_RESET;
        else if (ec_status_wr) user_reg <= ec_status_wdata &
                                           kbg_pkg::ST_USER_MASK; // RULE_02
    end

    // data buffers keep contents across bus reset
    always_ff @(posedge clk_sys) begin
        if (wr_data_cmd) host_buffer_reg <= host_wdata; // RULE_11
    end
    assign ec_in_data = host_buffer_reg;

    always_ff @(posedge clk_sys) begin
        if (ec_out_wr) out_buffer_reg <= ec_out_wdata;
    end

    // host read answer, one cycle after the strobe
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            host_rdata  <= 8'h00;
            host_rd_ack <= 1'b0;
        end else begin
            host_rd_ack <= rd_data || rd_status || rd_fast;
            if (rd_status)
                host_rdata <= status_next; // RULE_07
            else if (rd_data)
                host_rdata <= out_buffer_reg;
            else if (rd_fast)
                host_rdata <= kbg_pkg::FAST_FIXED |
                              {6'h00, fast_gate_reg, fast_rst_reg}; // RULE_13
            else
                host_rdata <= kbg_pkg::UNMAPPED_DATA;
        end
    end

    // interrupt views of the flags
    assign kb_irq = enable_flags ? (obf_reg & kb_irq_port_bit)
                                 : kb_irq_port_bit; // RULE_08
    assign input_full_irq_n = !ibf_reg; // RULE_05

    // serial lines pulled low while in bus reset
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            kb_clock_line_oe  <= 1'b1; // RULE_11
            kb_data_line_oe   <= 1'b1;
            aux_clock_line_oe <= 1'b1;
            aux_data_line_oe  <= 1'b1;
        end else begin
            kb_clock_line_oe  <= kb_clock_drive_low;
            kb_data_line_oe   <= kb_data_drive_low;
            aux_clock_line_oe <= aux_clock_drive_low;
            aux_data_line_oe  <= aux_data_drive_low;
        end
    end
    assign kb_clock_line_o  = 1'b0;
    assign kb_data_line_o   = 1'b0;
    assign aux_clock_line_o = 1'b0;
    assign aux_data_line_o  = 1'b0;

    // 12 MHz tick from reference pin edges, fractional accumulator
    always_ff @(posedge clk_sys) begin
        if (reset) ref_sync_reg <= 3'h0;
        else       ref_sync_reg <= {ref_sync_reg[1:0], ref_clk_pin};
    end
    assign acc_sum = acc_reg + CTRL_KHZ_W;
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            acc_reg       <= 16'h0000;
            ctrl_clk_tick <= 1'b0;
        end else if (ref_sync_reg[1] && !ref_sync_reg[2]) begin
            if (acc_sum >= REF_KHZ_W) begin
                acc_reg       <= acc_sum - REF_KHZ_W; // RULE_09
                ctrl_clk_tick <= 1'b1;
            end else begin
                acc_reg       <= acc_sum;
                ctrl_clk_tick <= 1'b0;
            end
        end else begin
            ctrl_clk_tick <= 1'b0;
        end
    end

    // controller reset stretch
    always_ff @(posedge clk_sys) begin
        if (reset) req_sync_reg <= 2'h0;
        else       req_sync_reg <= {req_sync_reg[0], ctrl_reset_req};
    end
    always_ff @(posedge clk_sys) begin
        if (reset || req_sync_reg[1]) begin
            rst_cnt_reg <= CTRL_RST_W; // RULE_10
            ctrl_reset  <= 1'b1;
        end else begin
            if (rst_cnt_reg != '0) rst_cnt_reg <= rst_cnt_reg - 1'b1;
            ctrl_reset <= (rst_cnt_reg != '0);
        end
    end

    // fast gate/reset port
    assign alt_start = wr_fast && host_wdata[kbg_pkg::FAST_RST_BIT] &&
                       !fast_rst_reg; // RULE_17
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            fast_gate_reg <= kbg_pkg::FAST_RESET[kbg_pkg::FAST_GATE_BIT];
            fast_rst_reg  <= kbg_pkg::FAST_RESET[kbg_pkg::FAST_RST_BIT]; // RULE_18
        end else if (wr_fast) begin
            fast_gate_reg <= host_wdata[kbg_pkg::FAST_GATE_BIT]; // RULE_14
            fast_rst_reg  <= host_wdata[kbg_pkg::FAST_RST_BIT];
        end
    end
    assign alt_gate_line = fast_gate_reg; // RULE_14

    kbg_alt_reset_timer #(
        .DELAY_CYC (ALT_DELAY_CYC), // RULE_16
        .PULSE_CYC (ALT_PULSE_CYC)
    ) u_alt_timer (
        .clk_sys (clk_sys),
        .reset   (reset),
        .start   (alt_start),
        .pulse_n (alt_pulse_n),
        .busy    (alt_busy)
    );
    assign alt_cpu_reset_n = alt_pulse_n; // RULE_18

    assign kbd_rst_comb_n = fast_en ? (alt_pulse_n & kbd_reset_n)
                                    : kbd_reset_n; // RULE_19
    always_ff @(posedge clk_sys) begin
        if (reset) kbd_cpu_reset <= gp_polarity_invert ? 1'b0 : 1'b1;
        else       kbd_cpu_reset <= gp_polarity_invert ? !kbd_rst_comb_n
                                                       : kbd_rst_comb_n;
    end

    assign cpu_addr20_mask_n = ctrl_gate_port_bit | fast_gate_reg; // RULE_20

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);

    ibf_set_a: assert property (wr_data_cmd |=> ibf_reg) // RULE_04
        else $error("input full not set by host write");
    cd_load_a: assert property (wr_data_cmd |=> // RULE_03
        cd_reg == $past(host_addr[kbg_pkg::CMD_SEL_BIT]))
        else $error("command flag not loaded from address");
    ibf_clear_a: assert property (ec_in_rd && !wr_data_cmd |=> // RULE_05
        !ibf_reg && input_full_irq_n)
        else $error("input full not cleared by controller read");
    obf_set_a: assert property (ec_out_wr |=> obf_reg && // RULE_06
        out_buffer_reg == $past(ec_out_wdata))
        else $error("output full not set");
    obf_clear_a: assert property (rd_data && enable_flags && !ec_out_wr
        |=> !obf_reg && !kb_irq) // RULE_08
        else $error("host read did not clear output full");
    status_read_a: assert property (rd_status |=> host_rd_ack && // RULE_07
        host_rdata[kbg_pkg::ST_IBF_BIT] == $past(ibf_reg))
        else $error("status read wrong");
    fast_read_a: assert property (rd_fast |=> // RULE_13
        (host_rdata & ~kbg_pkg::FAST_LIVE_MASK) == kbg_pkg::FAST_FIXED)
        else $error("fast port fixed bits wrong");
    fast_block_a: assert property (host_wr && !fast_en |=> // RULE_12
        $stable(fast_gate_reg) && $stable(fast_rst_reg))
        else $error("fast port written while disabled");
    gate_follow_a: assert property (wr_fast |=> alt_gate_line == // RULE_14
        $past(host_wdata[kbg_pkg::FAST_GATE_BIT]))
        else $error("alternate gate not following write");
    no_retrig_a: assert property (wr_fast && fast_rst_reg |=> // RULE_17
        !$rose(alt_busy))
        else $error("pulse retriggered without clearing bit");
    mask_gate_a: assert property (!cpu_addr20_mask_n |-> // RULE_20
        !alt_gate_line && !ctrl_gate_port_bit)
        else $error("address mask low with a gate high");
    rst_hold_a: assert property ($fell(reset) |-> // RULE_10
        ctrl_reset [*8])
        else $error("controller reset released early");

    cmd_write_c: cover property (wr_data_cmd &&
        host_addr[kbg_pkg::CMD_SEL_BIT]);
    alt_pulse_c: cover property ($fell(alt_cpu_reset_n));
    obf_clear_c: cover property (obf_reg ##1 !obf_reg);
    set_clear_c: cover property (wr_data_cmd && ec_in_rd);

endmodule : kbg_top

//--- test/kbg_host.sv
`timescale 1ns/1ns
module kbg_host (
    input  wire logic        clk_sys,
    output logic             host_wr,
    output logic             host_rd,
    output logic      [15:0] host_addr,
    output logic      [7:0]  host_wdata,
    input  wire logic [7:0]  host_rdata,
    input  wire logic        host_rd_ack
);
    initial begin
        host_wr    = 1'b0;
        host_rd    = 1'b0;
        host_addr  = 16'h0000;
        host_wdata = 8'h00;
    end

    // released lines show the inverse, never the old value
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        host_wr    <= 1'b1;
        host_addr  <= a;
        host_wdata <= d;
        @(posedge clk_sys);
        host_wr    <= 1'b0;
        host_addr  <= ~a;
        host_wdata <= ~d;
    endtask : wr

    // answer taken within two edges of the strobe
    task automatic rd(input logic [15:0] a, output logic [7:0] d,
                      output logic ok);
        ok = 1'b0;
        d  = 8'h00;
        @(posedge clk_sys);
        host_rd   <= 1'b1;
        host_addr <= a;
        repeat (2) begin
            @(posedge clk_sys);
            host_rd   <= 1'b0;
            host_addr <= ~a;
            #1;
            if (host_rd_ack === 1'b1 && ok === 1'b0) begin
                ok = 1'b1;
                d  = host_rdata;
            end
        end
    endtask : rd
endmodule : kbg_host

//--- test/kbg_top_tb.sv
`timescale 1ns/1ns
module kbg_top_tb;
    localparam int DLY = 100;
    localparam int PLS = 50;
    localparam logic [2:0] HW = 3'h0, HR = 3'h1, EO = 3'h2, EI = 3'h3;
    localparam logic [2:0] ES = 3'h4;
    localparam logic [15:0] FP = kbg_pkg::ADDR_FAST;
    typedef struct packed {
        logic [2:0]  op;
        logic [15:0] a;
        logic [7:0]  v;
        logic [7:0]  st;
    } kbg_row_t;
    localparam kbg_row_t ROWS [17] = '{
        '{HR, 16'h0064, 8'h00, 8'h00}, '{HW, 16'h0060, 8'hAB, 8'h02},
        '{EI, 16'h0000, 8'hAB, 8'h00}, '{HW, 16'h0064, 8'h5C, 8'h0A},
        '{HR, 16'h0064, 8'h0A, 8'h0A}, '{EI, 16'h0000, 8'h5C, 8'h08},
        '{EO, 16'h0000, 8'h3C, 8'h09}, '{HR, 16'h0060, 8'h3C, 8'h08},
        '{ES, 16'h0000, 8'hFF, 8'hFC}, '{HW, 16'h0060, 8'h11, 8'hF6},
        '{HR, 16'h0064, 8'hF6, 8'hF6}, '{ES, 16'h0000, 8'h00, 8'h02},
        '{EI, 16'h0000, 8'h11, 8'h00}, '{HR, 16'h0092, 8'h24, 8'h00},
        '{HW, 16'h0092, 8'hFE, 8'h00}, '{HR, 16'h0092, 8'h26, 8'h00},
        '{HW, 16'h0092, 8'h00, 8'h00}
    };
    logic        clk_sys, reset, ec_in_rd, ec_out_wr, ec_status_wr;
    logic        enable_flags, kb_irq_port_bit, ref_clk_pin, ok;
    logic        ctrl_reset_req, ctrl_gate_port_bit, kbd_reset_n;
    logic        gp_polarity_invert, host_wr, host_rd, host_rd_ack;
    logic        kb_irq, input_full_irq_n, ctrl_clk_tick, ctrl_reset;
    logic        alt_gate_line, alt_cpu_reset_n, kbd_cpu_reset;
    logic        cpu_addr20_mask_n;
    logic [7:0]  ec_out_wdata, ec_status_wdata, kbd_reset_gate_cfg;
    logic [7:0]  host_wdata, host_rdata, ec_in_data, ec_status, rd_data;
    logic [15:0] host_addr;
    logic [3:0]  drv, oe;
    int          n_errors, compares, cnt;

    kbg_top #(.ALT_DELAY_NS(DLY * 10), .ALT_PULSE_NS(PLS * 10)) i_kbg_top (
        .clk_sys, .reset, .host_wr, .host_rd, .host_addr, .host_wdata,
        .host_rdata, .host_rd_ack, .ec_in_rd, .ec_in_data, .ec_out_wr,
        .ec_out_wdata, .ec_status_wr, .ec_status_wdata, .ec_status,
        .enable_flags, .kb_irq_port_bit, .kb_irq, .input_full_irq_n,
        .kb_clock_drive_low(drv[3]), .kb_data_drive_low(drv[2]),
        .aux_clock_drive_low(drv[1]), .aux_data_drive_low(drv[0]),
        .kb_clock_line_o(), .kb_clock_line_oe(oe[3]),
        .kb_data_line_o(), .kb_data_line_oe(oe[2]),
        .aux_clock_line_o(), .aux_clock_line_oe(oe[1]),
        .aux_data_line_o(), .aux_data_line_oe(oe[0]),
        .ref_clk_pin, .ctrl_clk_tick, .ctrl_reset_req, .ctrl_reset,
        .kbd_reset_gate_cfg, .ctrl_gate_port_bit, .kbd_reset_n,
        .gp_polarity_invert, .alt_gate_line, .alt_cpu_reset_n,
        .kbd_cpu_reset, .cpu_addr20_mask_n
    );
    kbg_host i_kbg_host (
        .clk_sys, .host_wr, .host_rd, .host_addr, .host_wdata, .host_rdata,
        .host_rd_ack
    );

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic conclude;
        if (n_errors == 0 && compares > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : conclude

    task automatic ec_op(input logic [2:0] op, input logic [7:0] v);
        @(posedge clk_sys);
        ec_out_wr       <= (op == EO);
        ec_in_rd        <= (op == EI);
        ec_status_wr    <= (op == ES);
        ec_out_wdata    <= v;
        ec_status_wdata <= v;
        @(posedge clk_sys);
        {ec_out_wr, ec_in_rd, ec_status_wr} <= 3'b000;
    endtask : ec_op

    task automatic wait_edges(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask : wait_edges

    // write 1 to the reset bit and time the low pulse
    task automatic alt_pulse(input logic want);
        int t;
        i_kbg_host.wr(FP, 8'h01);
        t = 0;
        while (alt_cpu_reset_n === 1'b1 && t < DLY + PLS) begin
            wait_edges(1);
            t++;
        end
        if (want) begin
            check(t >= DLY && t <= DLY + 2, 1'b1);
            cnt = 0;
            while (alt_cpu_reset_n === 1'b0 && cnt < 2 * PLS) begin
                wait_edges(1);
                cnt++;
                if (cnt == 3) check(kbd_cpu_reset, 1'b0);
            end
            check(cnt == PLS, 1'b1);
        end else begin
            check(alt_cpu_reset_n, 1'b1);
        end
    endtask : alt_pulse

    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    initial begin
        ref_clk_pin = 1'b0;
        #3;
        forever #35 ref_clk_pin = ~ref_clk_pin;
    end

    initial begin
        #100000;
        n_errors++;
        conclude();
    end

    initial begin
        n_errors = 0;
        compares = 0;
        reset = 1'b1;
        {ec_in_rd, ec_out_wr, ec_status_wr, ctrl_reset_req} = 4'h0;
        {ctrl_gate_port_bit, gp_polarity_invert} = 2'b00;
        {enable_flags, kb_irq_port_bit, kbd_reset_n} = 3'b111;
        {ec_out_wdata, ec_status_wdata} = 16'h0000;
        kbd_reset_gate_cfg = 8'h04;
        drv = 4'h0;
        wait_edges(10);
        check(oe, 4'hF);
        check(ec_status, 8'h00);
        check(alt_cpu_reset_n, 1'b1);
        check(alt_gate_line, 1'b0);
        check(kbd_cpu_reset, 1'b1);
        @(posedge clk_sys);
        reset <= 1'b0;
        foreach (ROWS[i]) begin
            case (ROWS[i].op)
                HW: i_kbg_host.wr(ROWS[i].a, ROWS[i].v);
                HR: begin
                    i_kbg_host.rd(ROWS[i].a, rd_data, ok);
                    check(ok, 1'b1);
                    check(rd_data, ROWS[i].v);
                end
                default: ec_op(ROWS[i].op, ROWS[i].v);
            endcase
            wait_edges(1);
            if (ROWS[i].op == EI) check(ec_in_data, ROWS[i].v);
            check(ec_status, ROWS[i].st);
            check(input_full_irq_n, !ROWS[i].st[1]);
            check(kb_irq, ROWS[i].st[0]);
        end
        for (int k = 0; k < 4; k++) begin
            @(posedge clk_sys);
            ctrl_gate_port_bit <= k[1];
            i_kbg_host.wr(FP, {6'h00, k[0], 1'b0});
            wait_edges(2);
            check(alt_gate_line, k[0]);
            check(cpu_addr20_mask_n, k != 0);
        end
        @(posedge clk_sys);
        kbd_reset_gate_cfg <= 8'h00;
        i_kbg_host.wr(FP, 8'h00);
        i_kbg_host.rd(FP, rd_data, ok);
        check(ok, 1'b0);
        check(alt_gate_line, 1'b1);
        @(posedge clk_sys);
        kbd_reset_gate_cfg <= 8'h04;
        alt_pulse(1'b1);
        alt_pulse(1'b0);
        i_kbg_host.wr(FP, 8'h00);
        alt_pulse(1'b1);
        @(posedge clk_sys);
        gp_polarity_invert <= 1'b1;
        wait_edges(3);
        check(kbd_cpu_reset, 1'b0);
        @(posedge clk_sys);
        gp_polarity_invert <= 1'b0;
        kbd_reset_n <= 1'b0;
        wait_edges(3);
        check(kbd_cpu_reset, 1'b0);
        @(posedge clk_sys);
        kbd_reset_n <= 1'b1;
        enable_flags <= 1'b0;
        kb_irq_port_bit <= 1'b0;
        wait_edges(1);
        check(kb_irq, 1'b0);
        @(posedge clk_sys);
        kb_irq_port_bit <= 1'b1;
        wait_edges(1);
        check(kb_irq, 1'b1);
        ec_op(EO, 8'h77);
        @(posedge clk_sys);
        drv <= 4'h5;
        reset <= 1'b1;
        wait_edges(2);
        check(oe, 4'hF);
        check(ec_status, 8'h00);
        @(posedge clk_sys);
        reset <= 1'b0;
        i_kbg_host.rd(FP, rd_data, ok);
        check(rd_data, 8'h24);
        check(alt_cpu_reset_n, 1'b1);
        @(posedge clk_sys);
        ctrl_reset_req <= 1'b1;
        repeat (5) @(posedge clk_sys);
        ctrl_reset_req <= 1'b0;
        wait_edges(150);
        check(ctrl_reset, 1'b1);
        wait_edges(20);
        check(ctrl_reset, 1'b0);
        cnt = 0;
        repeat (1000) begin
            wait_edges(1);
            cnt += ctrl_clk_tick;
        end
        check(cnt >= 118 && cnt <= 121, 1'b1);
        conclude();
    end
endmodule : kbg_top_tb
